// [shared/interval_timer_pkg.sv]
// Package with the register map, field layout and types of the interval timer.
package interval_timer_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET   = 12'h310;
  localparam logic [11:0] STATUS_OFFSET = 12'h314;
  localparam logic [11:0] MASK_OFFSET   = 12'h318;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          RUN_BIT      = 0;
  localparam int          SEL_LSB      = 1;
  localparam int          SEL_MSB      = 2;
  localparam int          GUARD_BIT    = 7;
  localparam int          TICK_BIT     = 0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CNT_W        = 14;
  localparam int          PERIOD_LOG2  = 14;
  localparam int          LF_FREQ_HZ   = 32768;
  localparam int          CLK_FREQ_HZ  = 40000000;
  // System clock cycles in one low-frequency period, rounded down.
  localparam int          LF_CYCLES    = CLK_FREQ_HZ / LF_FREQ_HZ;

  typedef struct packed {
    logic       guard;
    logic [1:0] period_select;
    logic       run;
  } ctrl_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Last count of a period of 2^(14 - select) low-frequency cycles: that length minus one.
  function automatic logic [CNT_W-1:0] period_last(input logic [1:0] sel);
    logic [CNT_W:0] span;
    span = (CNT_W+1)'(1) << (PERIOD_LOG2 - int'(sel));
    return CNT_W'(span - (CNT_W+1)'(1));
  endfunction : period_last

endpackage : interval_timer_pkg

// [src/lf_period_counter.sv]
// Period counter advanced by low-frequency clock edges.
`timescale 1ns/10ps
`default_nettype none
module lf_period_counter
  import interval_timer_pkg::*;
(
  input  wire logic             clk,       // System clock.
  input  wire logic             rst_n,     // Asynchronous reset, low.
  input  wire logic             run,       // Count enable; low clears.
  input  wire logic             advance,   // One low-frequency edge.
  input  wire logic [CNT_W-1:0] last,      // Last count of the period.
  output logic      [CNT_W-1:0] count,     // Current count.
  output logic                  done       // Period completes now.
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // The compare is >= so that a shorter period chosen mid-count still wraps.
  always_comb begin
    done       = run && advance && (count_reg >= last);
    count_next = count_reg;
    if (!run) begin
      count_next = '0;
    end else if (done) begin
      count_next = '0;
    end else if (advance) begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : lf_period_counter
`default_nettype wire

// [src/low_freq_interval_timer.sv]
// Low-frequency interval timer with register port and interrupt.
//
// Behaviour
// - Period select 00..11 gives 2^14, 2^13, 2^12, 2^11 low-frequency cycles.
// - Run bit 0 holds the counter stopped and cleared; 1 lets it count.
// - Counter advances only on edges of the 32.768 kHz low-frequency clock.
// - Period event wakes the device from standby, except in stop mode.
// - Counting continues in any mode while the low-frequency clock runs.
`timescale 1ns/10ps
`default_nettype none
module low_freq_interval_timer
  import interval_timer_pkg::*;
(
  input  wire logic        clk,               // System clock, 40 MHz.
  input  wire logic        rst_n,             // Asynchronous reset, low.
  input  wire logic        low_freq_clock,    // 32.768 kHz clock pin.
  input  wire logic        stop_mode,         // Device is in stop mode.
  input  wire logic [11:0] addr,              // Register address.
  input  wire logic [7:0]  wdata,             // Register write data.
  input  wire logic        wr,                // Write strobe.
  input  wire logic        rd,                // Read strobe.
  output logic      [7:0]  rdata,             // Read data, cycle after rd.
  output logic             interval_tick_irq, // One-cycle period pulse.
  output logic             wake_req,          // One-cycle standby wake.
  output logic             irq                // Level interrupt.
);
  import interval_timer_pkg::*;

  // ****************************************************************
  // Low-frequency clock sampling
  // ****************************************************************
  // The pin is asynchronous to clk; only the second and third stages are looked at.
  logic lf_meta_reg, lf_sync_reg, lf_prev_reg;
  logic lf_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_meta_reg <= 1'b0;
      lf_sync_reg <= 1'b0;
      lf_prev_reg <= 1'b0;
    end else begin
      lf_meta_reg <= low_freq_clock;
      lf_sync_reg <= lf_meta_reg;
      lf_prev_reg <= lf_sync_reg;
    end
  end

  assign lf_rise = lf_sync_reg && !lf_prev_reg;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg_req_t   req;
  ctrl_t      ctrl_reg, ctrl_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       tick_reg, wake_reg, irq_reg;
  logic       tick_next, wake_next, irq_next;
  logic [CNT_W-1:0] cnt;
  logic       done;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  always_comb begin
    ctrl_next   = ctrl_reg;
    status_next = status_reg;
    mask_next   = mask_reg;
    rdata_next  = 8'h00;
    if (req.wr) begin
      if (req.addr == CTRL_OFFSET) begin
        ctrl_next.run           = req.wdata[RUN_BIT];
        ctrl_next.period_select = req.wdata[SEL_MSB:SEL_LSB];
        ctrl_next.guard         = req.wdata[GUARD_BIT];
      end else if (req.addr == STATUS_OFFSET) begin
        status_next = status_reg & ~req.wdata;
      end else if (req.addr == MASK_OFFSET) begin
        mask_next = req.wdata;
      end
    end
    // A period event in the clearing cycle is kept: set wins.
    if (done) begin
      status_next[TICK_BIT] = 1'b1;
    end
    if (req.rd) begin
      if (req.addr == CTRL_OFFSET) begin
        rdata_next[RUN_BIT]         = ctrl_reg.run;
        rdata_next[SEL_MSB:SEL_LSB] = ctrl_reg.period_select;
        rdata_next[GUARD_BIT]       = ctrl_reg.guard;
      end else if (req.addr == STATUS_OFFSET) begin
        rdata_next = status_reg;
      end else if (req.addr == MASK_OFFSET) begin
        rdata_next = mask_reg;
      end
    end
    tick_next = done;
    // No wake is raised in stop mode, though the counter and tick keep running there.
    wake_next = done && !stop_mode;
    irq_next  = |(status_next & mask_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= ctrl_t'(CTRL_RESET[3:0]);
      status_reg <= STATUS_RESET;
      mask_reg   <= MASK_RESET;
      rdata_reg  <= 8'h00;
      tick_reg   <= 1'b0;
      wake_reg   <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      tick_reg   <= tick_next;
      wake_reg   <= wake_next;
      irq_reg    <= irq_next;
    end
  end

  // ****************************************************************
  // Period counter
  // ****************************************************************
  // No mode input gates the counter: it runs whenever lf edges arrive.
  lf_period_counter u_counter (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (ctrl_reg.run),
    .advance (lf_rise),
    .last    (period_last(ctrl_reg.period_select)),
    .count   (cnt),
    .done    (done)
  );

  assign rdata             = rdata_reg;
  assign interval_tick_irq = tick_reg;
  assign wake_req          = wake_reg;
  assign irq               = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // A select change inside a period may shorten that one period, so the
  // exact-length check is relaxed until the next wrap or stop.
  logic sel_moved_reg;
  logic sel_moved_next;

  always_comb begin
    sel_moved_next = sel_moved_reg;
    if (!ctrl_reg.run || done) begin
      sel_moved_next = 1'b0;
    end
    if (ctrl_next.period_select != ctrl_reg.period_select) begin
      sel_moved_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_moved_reg <= 1'b0;
    end else begin
      sel_moved_reg <= sel_moved_next;
    end
  end

  sequence s_counting_edge;
    ctrl_reg.run && lf_rise && !done;
  endsequence

  sequence s_period_end;
    done ##1 tick_reg;
  endsequence

  property p_period_length;
    @(posedge clk) disable iff (!rst_n)
      done |-> sel_moved_reg || (cnt == period_last(ctrl_reg.period_select));
  endproperty
  a_period_length: assert property (p_period_length)
    else $error("period ended away from the selected count");

  property p_stop_clear;
    @(posedge clk) disable iff (!rst_n)
      !ctrl_reg.run |=> cnt == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("counter not cleared while stopped");

  property p_lf_only;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_reg.run && !lf_rise) |=> $stable(cnt);
  endproperty
  a_lf_only: assert property (p_lf_only)
    else $error("counter moved without a low-frequency edge");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      (done && !stop_mode) |=> wake_reg ##1 !wake_reg;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request missing or too long");

  property p_no_wake_stop;
    @(posedge clk) disable iff (!rst_n)
      stop_mode |=> !wake_reg;
  endproperty
  a_no_wake_stop: assert property (p_no_wake_stop)
    else $error("wake request raised in stop mode");

  property p_count_up;
    @(posedge clk) disable iff (!rst_n)
      s_counting_edge |=> cnt == $past(cnt) + CNT_W'(1);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not advance on a low-frequency edge");

  property p_wrap_pulse;
    @(posedge clk) disable iff (!rst_n)
      s_period_end |-> cnt == '0 ##1 !tick_reg;
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse)
    else $error("period end did not wrap or pulse once");

  property p_status_set;
    @(posedge clk) disable iff (!rst_n)
      done |=> status_reg[TICK_BIT];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("period event lost from status");

endmodule : low_freq_interval_timer
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the low-frequency interval timer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import interval_timer_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        lf;
  logic        stop_mode;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        wake;
  logic        irq;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  v;
  logic [7:0]  d;
  int          mismatches;
  int          n_checks;
  int          ticks;
  int          wakes;
  int          seed;
  int          ctrl_m;

  // ****************************************************************
  // Clock, design and event counters
  // ****************************************************************
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  low_freq_interval_timer dut (
    .clk(clk), .rst_n(rst_n), .low_freq_clock(lf), .stop_mode(stop_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .interval_tick_irq(tick), .wake_req(wake), .irq(irq));

  always @(posedge clk) begin
    if (tick === 1'b1) ticks++;
    if (wake === 1'b1) wakes++;
  end

  // ****************************************************************
  // Compare, bus and stimulus tasks
  // ****************************************************************
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_evt(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_evt

  task automatic wreg(input logic [11:0] a, input logic [7:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [11:0] a, output logic [7:0] x);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    x = rdata;
  endtask : rreg

  // Pulses are spaced three cycles so each one clears the synchroniser.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      lf <= 1'b1;
      @(posedge clk);
      lf <= 1'b0;
      @(posedge clk);
    end
  endtask : pulses

  // One full period: nothing after p-1 edges, one event on edge p.
  task automatic period(input int s);
    int p;
    int t0;
    int w0;
    p  = 1 << (PERIOD_LOG2 - s);
    t0 = ticks;
    w0 = wakes;
    pulses(p - 1);
    repeat (8) @(posedge clk);
    chk_evt(ticks - t0, 0);
    pulses(1);
    repeat (8) @(posedge clk);
    chk_evt(ticks - t0, 1);
    chk_evt(wakes - w0, (stop_mode === 1'b1) ? 0 : 1);
  endtask : period

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {rst_n, lf, stop_mode, wr, rd, addr, wdata} = '0;
    seed = 32'h1799;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (v[i]) if (i < 4) begin
      rreg(CTRL_OFFSET + 12'(4 * i), d);
      chk_reg(d, 8'h00);
    end
    repeat (8) begin
      d = 8'($random(seed));
      ctrl_m = int'(d) & 'h87;
      wreg(CTRL_OFFSET, d);
      wreg(12'h31C, d);
      rreg(CTRL_OFFSET, v);
      chk_reg(v, 8'(ctrl_m));
      rreg(12'h31C, v);
      chk_reg(v, 8'h00);
    end
    $display("test registers done");
    wreg(CTRL_OFFSET, 8'h07);
    repeat (50) @(posedge clk);
    chk_evt(ticks, 0);
    pulses(100);
    wreg(CTRL_OFFSET, 8'h06);
    pulses(10);
    wreg(CTRL_OFFSET, 8'h07);
    period(3);
    period(3);
    $display("test clear and restart done");
    for (int s = 2; s >= 0; s--) begin
      stop_mode <= (s == 2);
      wreg(CTRL_OFFSET, 8'h00);
      wreg(CTRL_OFFSET, 8'(s * 2 + 1));
      period(s);
    end
    $display("test periods done");
    rreg(STATUS_OFFSET, v);
    chk_reg(v, 8'h01);
    chk_evt(32'(irq), 0);
    wreg(MASK_OFFSET, 8'h01);
    repeat (2) @(negedge clk);
    chk_evt(32'(irq), 1);
    wreg(STATUS_OFFSET, 8'h01);
    repeat (2) @(negedge clk);
    chk_evt(32'(irq), 0);
    rreg(STATUS_OFFSET, v);
    chk_reg(v, 8'h00);
    $display("test interrupt done");
    results();
  end

  // A hang counts as a mismatch and ends through the same closing task.
  initial begin
    repeat (105000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : testbench
`default_nettype wire
